/* design/lldi_device.sv */
// Device-side logic: command decode, bank storage, DDR read/write paths, refresh rows
`timescale 1ns/1ps
module lldi_device #(
   parameter int ROW_BITS = 2,
   parameter int COL_BITS = 2
) (
   // Command clock domain
   input  wire logic                   ref_clk,
   input  wire logic                   rst,
   input  wire lldi_pkg::lldi_cmd_t    cmd,
   // Write data link
   input  wire logic                   write_data_clock,
   input  wire logic                   wdata_valid,
   input  wire logic [lldi_pkg::DQ_W-1:0] dq_in,
   // Read data and strobes
   output logic [lldi_pkg::DQ_W-1:0]   dq_rise,
   output logic [lldi_pkg::DQ_W-1:0]   dq_fall,
   output logic                        dq_oe_n,
   output logic                        read_valid,
   output logic [lldi_pkg::NUM_STROBES-1:0] read_strobe_clock,
   output logic [lldi_pkg::NUM_STROBES-1:0] read_strobe_clock_n,
   // Status
   output logic [1:0]                  burst_length,
   output logic [ROW_BITS-1:0]         refresh_row
);
   localparam int IDX_W   = lldi_pkg::BANK_W + ROW_BITS + COL_BITS;
   localparam int ENTRIES = 1 << IDX_W;
   localparam int PAIR_W  = 2 * lldi_pkg::DQ_W;

   // ****************************************************************
   // Command decode
   // ****************************************************************
   lldi_pkg::lldi_state_t state;
   logic [PAIR_W-1:0]     mem [ENTRIES];
   logic [ROW_BITS-1:0]   ref_row [lldi_pkg::NUM_BANKS];
   logic [IDX_W-1:0]      idx;
   logic [1:0]            pairs_left;
   wire  is_idle   = (state == lldi_pkg::LLDI_IDLE);
   wire  sel       = ~cmd.cs_n;
   wire  cmd_write = sel & ~cmd.we_n & cmd.ref_n;
   wire  cmd_read  = sel & cmd.we_n & cmd.ref_n;
   wire  cmd_ref   = sel & cmd.we_n & ~cmd.ref_n;
   wire  cmd_mrs   = sel & ~cmd.we_n & ~cmd.ref_n;
   wire  [IDX_W-1:0] cmd_idx = {cmd.bank, cmd.addr[COL_BITS +: ROW_BITS],
                                cmd.addr[COL_BITS-1:0]};
   // Clock pairs per burst minus one: two words travel per cycle
   wire  [1:0] burst_pairs = (burst_length == lldi_pkg::BL_8) ? 2'h3 :
                             (burst_length == lldi_pkg::BL_4) ? 2'h1 : 2'h0;
   wire  [ROW_BITS-1:0] next_ref_row = ref_row[cmd.bank] + ROW_BITS'(1);
   wire  [COL_BITS-1:0] next_col = idx[COL_BITS-1:0] + COL_BITS'(1);
   wire  [IDX_W-1:0]    next_idx = {idx[IDX_W-1:COL_BITS], next_col};

   // ****************************************************************
   // Write data link domain
   // ****************************************************************
   // Reset is carried into the link domain; the link clock may stop
   logic lrst_s1, lrst;
   logic [lldi_pkg::DQ_W-1:0] rise_word;
   logic                      rise_ok;
   logic [PAIR_W-1:0]         link_pair;
   logic                      link_tog;

   always_ff @(posedge write_data_clock) begin
      lrst_s1 <= rst;
      lrst    <= lrst_s1;
   end

   always_ff @(posedge write_data_clock) begin
      rise_word <= dq_in;
      rise_ok   <= wdata_valid & ~lrst;
   end

   // Pair completes on the falling edge; it stays put for a whole link period
   always_ff @(negedge write_data_clock) begin
      if (lrst) begin
         link_tog <= 1'b0;
      end else if (rise_ok) begin
         link_pair <= {dq_in, rise_word};
         link_tog  <= ~link_tog;
      end
   end

   // ****************************************************************
   // Crossing into the command clock domain
   // ****************************************************************
   logic tog_s1, tog_s2, tog_s3;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tog_s1 <= 1'b0;
         tog_s2 <= 1'b0;
         tog_s3 <= 1'b0;
      end else begin
         tog_s1 <= link_tog;
         tog_s2 <= tog_s1;
         tog_s3 <= tog_s2;
      end
   end
   wire beat = tog_s2 ^ tog_s3;
   wire wr_beat = (state == lldi_pkg::LLDI_WRITE) & beat;

   // ****************************************************************
   // Control and storage
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state        <= lldi_pkg::LLDI_IDLE;
         idx          <= '0;
         pairs_left   <= 2'h0;
         burst_length <= lldi_pkg::BL_RESET;
         refresh_row  <= '0;
         for (int b = 0; b < lldi_pkg::NUM_BANKS; b++) begin
            ref_row[b] <= '0;
         end
      end else begin
         case (state)
            lldi_pkg::LLDI_IDLE: begin
               if (cmd_read) begin
                  state      <= lldi_pkg::LLDI_READ;
                  idx        <= cmd_idx;
                  pairs_left <= burst_pairs;
               end else if (cmd_write) begin
                  state      <= lldi_pkg::LLDI_WRITE;
                  idx        <= cmd_idx;
                  pairs_left <= burst_pairs;
               end else if (cmd_ref) begin
                  ref_row[cmd.bank] <= next_ref_row;
                  refresh_row       <= next_ref_row;
               end else if (cmd_mrs && cmd.addr[lldi_pkg::BL_POS +: 2] != 2'h3) begin
                  burst_length <= cmd.addr[lldi_pkg::BL_POS +: 2];
               end
            end
            lldi_pkg::LLDI_READ: begin
               idx        <= next_idx;
               pairs_left <= pairs_left - 2'h1;
               if (pairs_left == 2'h0) begin
                  state <= lldi_pkg::LLDI_IDLE;
               end
            end
            lldi_pkg::LLDI_WRITE: begin
               if (beat) begin
                  idx        <= next_idx;
                  pairs_left <= pairs_left - 2'h1;
                  if (pairs_left == 2'h0) begin
                     state <= lldi_pkg::LLDI_IDLE;
                  end
               end
            end
            default: state <= lldi_pkg::LLDI_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (wr_beat) begin
         mem[idx] <= link_pair;
      end
   end

   // ****************************************************************
   // Read output: one word per clock half, strobes edge per cycle
   // ****************************************************************
   // All four pairs toggle together so two-pair capture on 0/1 stays valid
   wire reading = (state == lldi_pkg::LLDI_READ);
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         dq_rise             <= '0;
         dq_fall             <= '0;
         dq_oe_n             <= 1'b1;
         read_valid          <= 1'b0;
         read_strobe_clock   <= '0;
         read_strobe_clock_n <= '1;
      end else begin
         dq_oe_n    <= ~reading;
         read_valid <= reading;
         if (reading) begin
            dq_rise             <= mem[idx][lldi_pkg::DQ_W-1:0];
            dq_fall             <= mem[idx][PAIR_W-1:lldi_pkg::DQ_W];
            read_strobe_clock   <= ~read_strobe_clock;
            read_strobe_clock_n <= read_strobe_clock;
         end
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   AST_BANK_SELECT: assert property (@(posedge ref_clk) disable iff (rst)
      (is_idle && cmd_read) |=> idx[IDX_W-1 -: lldi_pkg::BANK_W] == $past(cmd.bank))
      else $error("Read did not select the commanded bank");
   AST_TWO_WORDS: assert property (@(posedge ref_clk) disable iff (rst)
      read_valid |-> !dq_oe_n && {dq_fall, dq_rise} == $past(mem[idx]))
      else $error("Read beat does not carry the stored pair");
   AST_STROBE_EDGE: assert property (@(posedge ref_clk) disable iff (rst)
      read_valid |-> read_strobe_clock != $past(read_strobe_clock))
      else $error("Read beat without a strobe transition");
   AST_CMD_SAMPLE: assert property (@(posedge ref_clk) disable iff (rst)
      (is_idle && cmd_write) |=> state == lldi_pkg::LLDI_WRITE)
      else $error("Write command not taken on the rising edge");
   AST_WRITE_ADVANCE: assert property (@(posedge ref_clk) disable iff (rst)
      wr_beat |=> idx[COL_BITS-1:0] == $past(next_col))
      else $error("Captured write pair did not advance the column");
   AST_BURST_EIGHT: assert property (@(posedge ref_clk) disable iff (rst)
      (is_idle && cmd_read && burst_length == lldi_pkg::BL_8)
      |=> ##1 read_valid [*4] ##1 !read_valid)
      else $error("Burst of eight did not last four cycles");
   AST_BURST_FOUR: assert property (@(posedge ref_clk) disable iff (rst)
      (is_idle && cmd_read && burst_length == lldi_pkg::BL_4)
      |=> ##1 read_valid [*2] ##1 !read_valid)
      else $error("Burst of four did not last two cycles");
   AST_BURST_TWO: assert property (@(posedge ref_clk) disable iff (rst)
      (is_idle && cmd_read && burst_length == lldi_pkg::BL_2)
      |=> ##1 read_valid ##1 !read_valid)
      else $error("Burst of two did not last one cycle");
   // The reserved code must leave the running burst length alone
   AST_MODE_KEEP: assert property (@(posedge ref_clk) disable iff (rst)
      (is_idle && cmd_mrs && cmd.addr[lldi_pkg::BL_POS +: 2] == 2'h3)
      |=> $stable(burst_length))
      else $error("Reserved burst code changed the burst length");
   AST_REFRESH_ROW: assert property (@(posedge ref_clk) disable iff (rst)
      (is_idle && cmd_ref) |=> refresh_row == $past(next_ref_row))
      else $error("Refresh did not step the bank row counter");
   AST_FOUR_PAIRS: assert property (@(posedge ref_clk) disable iff (rst)
      (&read_strobe_clock || ~|read_strobe_clock) && read_strobe_clock_n == ~read_strobe_clock)
      else $error("Strobe pairs out of step or not complementary");
   AST_PAIR_ONE: assert property (@(posedge ref_clk) disable iff (rst)
      read_strobe_clock[0] == read_strobe_clock[1])
      else $error("Pairs zero and one disagree");
endmodule

/* design/lldi_pkg.sv */
// Shared constants and carriers for the low-latency DRAM interface device
package lldi_pkg;
   // ****************************************************************
   // Geometry
   // ****************************************************************
   localparam int NUM_BANKS   = 16;
   localparam int BANK_W      = 4;
   localparam int ADDR_W      = 20;
   localparam int DQ_W        = 36;
   localparam int NUM_STROBES = 4;
   localparam int LANE_GROUP  = 9;
   // ****************************************************************
   // Mode register field: burst length code in the low address bits
   // ****************************************************************
   localparam int         BL_POS   = 0;
   localparam logic [1:0] BL_2     = 2'h0;
   localparam logic [1:0] BL_4     = 2'h1;
   localparam logic [1:0] BL_8     = 2'h2;
   localparam logic [1:0] BL_RESET = 2'h0;
   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic              cs_n;
      logic              we_n;
      logic              ref_n;
      logic [BANK_W-1:0] bank;
      logic [ADDR_W-1:0] addr;
   } lldi_cmd_t;

   typedef enum logic [1:0] {
      LLDI_IDLE  = 2'h0,
      LLDI_READ  = 2'h1,
      LLDI_WRITE = 2'h2
   } lldi_state_t;
endpackage

/* bench/lldi_ctrl_model.sv */
// Controller model: drives the write data link and its clock
`timescale 1ns/1ps
module lldi_ctrl_model (
   // Write data link
   output logic                      write_data_clock,
   output logic                      wdata_valid,
   output logic [lldi_pkg::DQ_W-1:0] dq_in
);
   initial begin
      write_data_clock = 1'b0;
      wdata_valid      = 1'b0;
      dq_in            = '0;
   end
   // ****************************************************************
   // One link period, 48 ns; the clock stands still between calls
   // ****************************************************************
   task automatic send_pair(input logic [lldi_pkg::DQ_W-1:0] r, f, input logic v);
      wdata_valid = v;
      dq_in = r;
      #12 write_data_clock = 1'b1;
      #12 dq_in = f;
      #12 write_data_clock = 1'b0;
      // Released lines show the inverse so stale data never passes; the release
      // sits mid low phase so a following call never reassigns in the same step
      #6 dq_in = ~f;
      wdata_valid = 1'b0;
      #6;
   endtask
endmodule

/* bench/low_latency_dram_interface_test.sv */
// Self-checking bench for the low-latency DRAM interface device
`timescale 1ns/1ps
module low_latency_dram_interface_test;
   // ****************************************************************
   // Signals
   // ****************************************************************
   logic                             ref_clk = 1'b0;
   logic                             rst     = 1'b1;
   lldi_pkg::lldi_cmd_t              cmd;
   logic                             write_data_clock, wdata_valid, dq_oe_n, read_valid;
   logic [lldi_pkg::DQ_W-1:0]        dq_in, dq_rise, dq_fall;
   logic [lldi_pkg::DQ_W-1:0]        pr [4];
   logic [lldi_pkg::DQ_W-1:0]        pf [4];
   logic [lldi_pkg::NUM_STROBES-1:0] rs, rs_n, prev;
   logic [1:0]                       burst_length, refresh_row, code;
   logic [lldi_pkg::BANK_W-1:0]      bank;
   logic [lldi_pkg::ADDR_W-1:0]      addr;
   logic [1:0]                       rows [lldi_pkg::NUM_BANKS] = '{default: 2'h0};
   logic [31:0]                      seed     = 32'hd255fba6;
   int                               fails    = 0;
   int                               compares = 0;

   always #2.5 ref_clk = ~ref_clk;

   lldi_device u_dut (.ref_clk(ref_clk), .rst(rst), .cmd(cmd),
      .write_data_clock(write_data_clock), .wdata_valid(wdata_valid), .dq_in(dq_in),
      .dq_rise(dq_rise), .dq_fall(dq_fall), .dq_oe_n(dq_oe_n), .read_valid(read_valid),
      .read_strobe_clock(rs), .read_strobe_clock_n(rs_n),
      .burst_length(burst_length), .refresh_row(refresh_row));
   lldi_ctrl_model u_ctrl (.write_data_clock(write_data_clock),
      .wdata_valid(wdata_valid), .dq_in(dq_in));
   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Pairs per burst: two words cross each data ball per clock
   function automatic int pairs_of(input logic [1:0] c);
      return (c == lldi_pkg::BL_8) ? 4 : (c == lldi_pkg::BL_4) ? 2 : 1;
   endfunction
   task automatic chk(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         fails++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask
   task automatic report_and_stop();
      if (fails == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Hold above one edge re-presents the command while busy, which must be ignored
   task automatic issue(input logic we_n, ref_n, input logic [3:0] b,
                        input logic [19:0] a, input int hold);
      @(negedge ref_clk);
      cmd = '{cs_n: 1'b0, we_n: we_n, ref_n: ref_n, bank: b, addr: a};
      repeat (hold) @(negedge ref_clk);
      cmd.cs_n = 1'b1;
   endtask
   task automatic read_chk(input logic [19:0] a, input int n, input int o);
      // Strobes hold their level while idle; the first beat may already stand on return
      prev = rs;
      issue(1'b1, 1'b1, bank, a, 2);
      for (int k = 0; k < 6 && read_valid !== 1'b1; k++) begin
         prev = rs;
         @(negedge ref_clk);
      end
      for (int b = 0; b < n; b++) begin
         chk(read_valid === 1'b1 && dq_oe_n === 1'b0, "read beat missing");
         chk(dq_rise === pr[(b+o)%4] && dq_fall === pf[(b+o)%4], "read data");
         chk(rs === ~prev && (rs === 4'h0 || rs === 4'hf), "strobe");
         chk(rs_n === ~rs, "strobe complement");
         prev = rs;
         @(negedge ref_clk);
      end
      chk(read_valid === 1'b0 && dq_oe_n === 1'b1, "burst too long");
   endtask
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      cmd = '{cs_n: 1'b1, we_n: 1'b1, ref_n: 1'b1, bank: '0, addr: '0};
      // Link reset is synchronised, so the link clock must run during reset
      fork
         repeat (10) @(negedge ref_clk);
         repeat (4) u_ctrl.send_pair('0, '0, 1'b0);
      join
      @(negedge ref_clk);
      rst = 1'b0;
      chk(burst_length === 2'h0 && dq_oe_n === 1'b1 && read_valid === 1'b0, "reset");
      chk(rs === 4'h0 && rs_n === 4'hf && refresh_row === 2'h0, "reset strobes");
      // The release of the link reset also needs link clock edges to pass through
      repeat (3) u_ctrl.send_pair('0, '0, 1'b0);
      for (int i = 0; i < 6; i++) begin
         code = 2'(i % 3);
         bank = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'(rnd());
         addr = 20'(rnd());
         issue(1'b0, 1'b0, '0, {18'h0, code}, 1);
         @(negedge ref_clk);
         chk(burst_length === code, "burst length");
         if (code == 2'h2) begin
            issue(1'b0, 1'b0, '0, 20'h3, 1);
            @(negedge ref_clk);
            chk(burst_length === 2'h2, "reserved code taken");
         end
         for (int p = 0; p < 4; p++) begin
            pr[p] = {4'(rnd()), rnd()};
            pf[p] = {4'(rnd()), rnd()};
         end
         issue(1'b0, 1'b1, bank, addr, 1);
         for (int p = 0; p < pairs_of(code); p++)
            u_ctrl.send_pair(pr[p], pf[p], 1'b1);
         repeat (10) @(negedge ref_clk);
         issue(1'b1, 1'b0, bank, 20'(rnd()), 1);
         @(negedge ref_clk);
         rows[bank] = rows[bank] + 2'h1;
         chk(refresh_row === rows[bank], "refresh row");
         for (int o = 0; o < ((code == 2'h2) ? 2 : 1); o++)
            read_chk({addr[19:2], 2'(addr[1:0] + o)}, pairs_of(code), o);
      end
      report_and_stop();
   end
   // Whole run takes a few microseconds
   initial begin
      #20000;
      fails++;
      report_and_stop();
   end
endmodule
